/* verilog/sch_host_ctrl.sv */
/*
 * Host-side control of a smart card interface: chip-select framed
 * serial port, chip addressing, I/O routing, pullup, attention
 * output, card supply enable and card clock selection.
 * Assumes all pins are asynchronous to clk and that clk is at least
 * ten times faster than the serial clock and four times faster than the card clock source.
 */
`timescale 1ns/1ps
module sch_host_ctrl
	import sch_pkg::*;
#(
	parameter int ADDR_BITS = 2
)
(
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic [ADDR_BITS-1:0] chipAddr,
	input  wire logic                 chipSelectN,
	input  wire logic                 spiClk,
	input  wire logic                 mosi,
	input  wire logic                 cardClkSrc,
	input  wire logic                 card_presence_in,
	input  wire logic                 supplyOverload,
	input  wire logic                 supplyUnderVolt,
	input  wire logic                 brownOut,
	input  wire logic                 pullup_enable_pin,
	input  wire logic                 hostIoIn,
	input  wire logic                 cardIoIn,
	output logic                      hostIoOut,
	output logic                      hostIoOe,
	output logic                      cardIoOut,
	output logic                      cardIoOe,
	output logic                      pullupOn,
	output logic                      misoOut,
	output logic                      misoOe,
	output logic                      attentionN,
	output logic                      card_supply_out,
	output logic                      card_clock_out
);
	initial begin
		if (ADDR_BITS != CMD_ADDR_HI - CMD_ADDR_LO + 1) begin
			$error("ADDR_BITS must match the command address field");
		end
	end

	// ------------------------------------------------------------
	// Pin resynchronisers: three stages, change once 2 and 3 agree
	// ------------------------------------------------------------
	logic [NUM_PINS-1:0] pins, s1_q, s2_q, s3_q, filt_q, filt_d, prev_q;
	assign pins = {pullup_enable_pin, cardIoIn, hostIoIn, brownOut,
		supplyUnderVolt, supplyOverload, card_presence_in, cardClkSrc,
		mosi, spiClk, chipSelectN};

	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q   <= PIN_IDLE;
			s2_q   <= PIN_IDLE;
			s3_q   <= PIN_IDLE;
			filt_q <= PIN_IDLE;
			prev_q <= PIN_IDLE;
		end else begin
			s1_q   <= pins;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			filt_q <= filt_d;
			prev_q <= filt_q;
		end
	end

	function automatic logic rose(input int idx);
		return filt_q[idx] & ~prev_q[idx];
	endfunction

	function automatic logic fell(input int idx);
		return ~filt_q[idx] & prev_q[idx];
	endfunction

	logic csLow, sckRise, sckFall, csFall;
	assign csLow   = ~filt_q[PIN_CSN];
	assign csFall  = fell(PIN_CSN);
	// Serial clock edges only move the frame, never card data
	assign sckRise = csLow & rose(PIN_SCK);
	assign sckFall = csLow & fell(PIN_SCK);

	// ------------------------------------------------------------
	// Serial frame: command in, status out
	// ------------------------------------------------------------
	sch_frame_t        frame_q, frame_d;
	logic [3:0]        bitCnt_q, bitCnt_d;
	logic [7:0]        shIn_q, shIn_d, shOut_q, shOut_d, status;
	logic [7:0]        fullByte;
	logic              selected_q, selected_d, misoOut_q, misoOut_d;
	logic              syncMode_q, syncMode_d, pwrReq_q, pwrReq_d;
	logic [1:0]        divSel_q, divSel_d;
	logic              readDone;
	logic pending_q, pending_d, ovlFault_q, ovlFault_d, ovlRise;
	logic attnN_q, attnN_d, supply_q, supply_d, event_now;

	assign fullByte = {shIn_q[6:0], filt_q[PIN_MOSI]};

	// Status snapshot; bits 7..5 stay zero for the host to discard
	always_comb begin
		status          = BYTE_ZERO;
		status[ST_PRES] = filt_q[PIN_PRES];
		status[ST_DATA] = syncMode_q ? filt_q[PIN_CIO]
			: card_supply_out;
		status[ST_OVL]  = ovlFault_q;
		status[ST_UV]   = filt_q[PIN_UV];
		status[ST_EVT]  = pending_q;
	end

	always_comb begin
		frame_d    = frame_q;
		bitCnt_d   = bitCnt_q;
		shIn_d     = shIn_q;
		shOut_d    = shOut_q;
		misoOut_d  = misoOut_q;
		selected_d = selected_q;
		syncMode_d = syncMode_q;
		divSel_d   = divSel_q;
		pwrReq_d   = pwrReq_q;
		readDone   = 1'b0;
		case (frame_q)
			FR_IDLE: begin
				if (csFall) begin
					frame_d   = FR_SHIFT;
					bitCnt_d  = CNT_ZERO;
					misoOut_d = status[BYTE_BITS-1];
					shOut_d   = {status[6:0], 1'b0};
				end
			end
			FR_SHIFT: begin
				if (sckRise) begin
					shIn_d   = fullByte;
					bitCnt_d = bitCnt_q + 4'h1;
					if (bitCnt_q == CNT_LAST) begin
						frame_d = FR_DONE;
						if (fullByte[CMD_ADDR_HI:CMD_ADDR_LO] == chipAddr) begin
							// Address captured, program applied
							selected_d = 1'b1;
							syncMode_d = fullByte[CMD_SYNC];
							divSel_d   = fullByte[CMD_DIV_HI:CMD_DIV_LO];
							pwrReq_d   = fullByte[CMD_PWR];
							readDone   = 1'b1;
						end
					end
				end
				if (sckFall) begin
					misoOut_d = shOut_q[BYTE_BITS-1];
					shOut_d   = {shOut_q[6:0], 1'b0};
				end
			end
			FR_DONE: begin
				misoOut_d = 1'b0;
			end
			default: frame_d = FR_IDLE;
		endcase
		// Chip select high ends every frame and drops selection
		if (!csLow) begin
			frame_d    = FR_IDLE;
			selected_d = 1'b0;
			misoOut_d  = 1'b0;
		end
		// Overload clears the supply request until reprogrammed
		if (ovlRise) begin
			pwrReq_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			frame_q    <= FR_IDLE;
			bitCnt_q   <= CNT_ZERO;
			shIn_q     <= BYTE_ZERO;
			shOut_q    <= BYTE_ZERO;
			misoOut_q  <= 1'b0;
			selected_q <= 1'b0;
			syncMode_q <= 1'b0;
			divSel_q   <= DIV_BY1;
			pwrReq_q   <= 1'b0;
		end else begin
			frame_q    <= frame_d;
			bitCnt_q   <= bitCnt_d;
			shIn_q     <= shIn_d;
			shOut_q    <= shOut_d;
			misoOut_q  <= misoOut_d;
			selected_q <= selected_d;
			syncMode_q <= syncMode_d;
			divSel_q   <= divSel_d;
			pwrReq_q   <= pwrReq_d;
		end
	end

	// ------------------------------------------------------------
	// Events, fault and attention output
	// ------------------------------------------------------------
	assign ovlRise   = rose(PIN_OVL);
	assign event_now = rose(PIN_PRES) | fell(PIN_PRES) | ovlRise;

	// Set wins over the read clear so no event slips through
	always_comb begin
		pending_d  = event_now | (pending_q & ~readDone);
		ovlFault_d = ovlRise | (ovlFault_q & ~readDone);
		supply_d   = pwrReq_d & ~filt_d[PIN_OVL];
		attnN_d    = filt_q[PIN_BO] | ~pending_q;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pending_q  <= 1'b0;
			ovlFault_q <= 1'b0;
			supply_q   <= 1'b0;
			attnN_q    <= 1'b1;
		end else begin
			pending_q  <= pending_d;
			ovlFault_q <= ovlFault_d;
			supply_q   <= supply_d;
			attnN_q    <= attnN_d;
		end
	end

	// ------------------------------------------------------------
	// I/O routing and pullup
	// ------------------------------------------------------------
	logic ioEn, hOe_q, hOe_d, cOe_q, cOe_d, pu_q, pu_d, mOe_q, mOe_d;
	assign ioEn = csLow & selected_q & ~syncMode_q;

	// Open-drain relay; a side already driving is not echoed back,
	// which avoids the two drivers latching each other low
	always_comb begin
		hOe_d = ioEn & ~filt_q[PIN_CIO] & ~cOe_q;
		cOe_d = ioEn & ~filt_q[PIN_HIO] & ~hOe_q;
		pu_d  = filt_q[PIN_PUE] & csLow & selected_q;
		mOe_d = csLow;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			hOe_q <= 1'b0;
			cOe_q <= 1'b0;
			pu_q  <= 1'b0;
			mOe_q <= 1'b0;
		end else begin
			hOe_q <= hOe_d;
			cOe_q <= cOe_d;
			pu_q  <= pu_d;
			mOe_q <= mOe_d;
		end
	end

	// Card clock, timed by the card clock source; forced low on the next clk while the supply is off
	sch_clk_div u_div (
		.clk      (clk),
		.rst      (rst),
		.run      (supply_q),
		.srcLevel (filt_q[PIN_CSRC]),
		.srcRise  (rose(PIN_CSRC)),
		.divSel   (divSel_q),
		.cardClk  (card_clock_out)
	);

	assign hostIoOut       = 1'b0;
	assign cardIoOut       = 1'b0;
	assign hostIoOe        = hOe_q;
	assign cardIoOe        = cOe_q;
	assign pullupOn        = pu_q;
	assign misoOut         = misoOut_q;
	assign misoOe          = mOe_q;
	assign attentionN      = attnN_q;
	assign card_supply_out = supply_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_last_bit;
		frame_q == FR_SHIFT && sckRise && bitCnt_q == CNT_LAST;
	endsequence

	a_io_gate: assert property ((hostIoOe | cardIoOe) |->
		$past(csLow) && $past(selected_q) && !$past(syncMode_q))
		else $error("translator driven while not enabled");
	a_sync_data: assert property (syncMode_q |->
		status[ST_DATA] == filt_q[PIN_CIO])
		else $error("status b3 not card data in sync mode");
	a_pullup_sel: assert property (pullupOn |-> $past(selected_q)
		&& $past(filt_q[PIN_PUE]))
		else $error("pullup on without select and enable");
	a_attn_event: assert property ((event_now && !filt_q[PIN_BO])
		##1 !filt_q[PIN_BO] |=> !attentionN)
		else $error("event did not pull attention low");
	a_brownout: assert property (filt_q[PIN_BO] |=> attentionN)
		else $error("attention low during brown-out");
	a_ovl_cut: assert property (ovlRise |=> !card_supply_out
		&& ovlFault_q)
		else $error("overload did not cut supply");
	a_miso_hiz: assert property (!csLow |=> !misoOe)
		else $error("serial output driven while deselected");
	a_read_clr: assert property ((s_last_bit ##0
		(fullByte[CMD_ADDR_HI:CMD_ADDR_LO] == chipAddr && !event_now))
		|=> !pending_q ##1 attentionN)
		else $error("status read did not release attention");
	a_cs_off: assert property ($rose(filt_q[PIN_CSN]) |=>
		frame_q == FR_IDLE && !selected_q)
		else $error("frame alive with chip select high");
	a_first_bit: assert property ((frame_q == FR_IDLE && csFall)
		|=> misoOut == $past(status[BYTE_BITS-1]))
		else $error("first status bit not presented");
endmodule

/* verilog/sch_pkg.sv */
/*
 * Shared constants for the smart card host control block: pin vector
 * layout, command byte fields, status byte fields and divider codes.
 * Assumes one system clock; every pin except rst and chipAddr is resynchronised in the top.
 */
package sch_pkg;
	// ------------------------------------------------------------
	// Pin vector layout
	// ------------------------------------------------------------
	localparam int NUM_PINS  = 11;
	localparam int PIN_CSN   = 0;
	localparam int PIN_SCK   = 1;
	localparam int PIN_MOSI  = 2;
	localparam int PIN_CSRC  = 3;
	localparam int PIN_PRES  = 4;
	localparam int PIN_OVL   = 5;
	localparam int PIN_UV    = 6;
	localparam int PIN_BO    = 7;
	localparam int PIN_HIO   = 8;
	localparam int PIN_CIO   = 9;
	localparam int PIN_PUE   = 10;
	// Idle level of each pin, so reset never leaves a false edge
	localparam logic [NUM_PINS-1:0] PIN_IDLE = 11'h705;

	// ------------------------------------------------------------
	// Command byte fields
	// ------------------------------------------------------------
	localparam int BYTE_BITS   = 8;
	localparam int CMD_ADDR_HI = 7;
	localparam int CMD_ADDR_LO = 6;
	localparam int CMD_SYNC    = 5;
	localparam int CMD_DIV_HI  = 4;
	localparam int CMD_DIV_LO  = 3;
	localparam int CMD_PWR     = 2;

	// ------------------------------------------------------------
	// Status byte fields (bits 7..5 read as zero)
	// ------------------------------------------------------------
	localparam int ST_PRES  = 4;
	localparam int ST_DATA  = 3;
	localparam int ST_OVL   = 2;
	localparam int ST_UV    = 1;
	localparam int ST_EVT   = 0;

	// ------------------------------------------------------------
	// Divider codes and reset values
	// ------------------------------------------------------------
	localparam logic [1:0] DIV_BY1 = 2'h0;
	localparam logic [1:0] DIV_BY2 = 2'h1;
	localparam logic [1:0] DIV_BY4 = 2'h2;
	localparam logic [3:0] CNT_LAST = 4'h7;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	typedef enum logic [1:0] {FR_IDLE, FR_SHIFT, FR_DONE} sch_frame_t;
endpackage

/* verilog/sch_clk_div.sv */
/*
 * Card clock generator: follows the source or divides it by 2 or 4.
 * Assumes srcLevel is the filtered source level and srcRise a one
 * cycle pulse on its rising edge, both on clk.
 */
`timescale 1ns/1ps
module sch_clk_div
	import sch_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       run,
	input  wire logic       srcLevel,
	input  wire logic       srcRise,
	input  wire logic [1:0] divSel,
	output logic            cardClk
);
	logic cardClk_q, cardClk_d;
	logic phase_q, phase_d;

	// ------------------------------------------------------------
	// Divider next state
	// ------------------------------------------------------------
	// Toggling only on source rising edges gives 50% whatever the
	// source duty; divide by one passes the source duty through
	always_comb begin
		cardClk_d = cardClk_q;
		phase_d   = phase_q;
		if (!run) begin
			cardClk_d = 1'b0; // Stopped low
			phase_d   = 1'b0;
		end else if (divSel == DIV_BY1) begin
			cardClk_d = srcLevel;
		end else if (srcRise) begin
			if (divSel == DIV_BY2) begin
				cardClk_d = ~cardClk_q;
			end else begin
				phase_d = ~phase_q;
				if (phase_q) begin
					cardClk_d = ~cardClk_q;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cardClk_q <= 1'b0;
			phase_q   <= 1'b0;
		end else begin
			cardClk_q <= cardClk_d;
			phase_q   <= phase_d;
		end
	end

	assign cardClk = cardClk_q;
endmodule

/* tb/sch_host_model.sv */
/*
 * Host model: frames one byte with chip select and captures the reply.
 * Assumes the bench clock on clk and a resolved serial return line.
 */
`timescale 1ns/1ps
module sch_host_model (
	input  wire logic clk,
	input  wire logic miso,
	output logic      csN,
	output logic      sck,
	output logic      mosiDrv
);
	// Serial clock stands low between frames
	initial begin
		csN = 1'h1;
		sck = 1'h0;
		mosiDrv = 1'h1;
	end

	// Pins only move on falling clk edges
	task automatic gap(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Half bit of 8 clk keeps each phase above the 5 clk floor
	task automatic xfer(input logic [7:0] cmd, input logic keep,
		output logic [4:0] st);
		logic [7:0] r;
		csN = 1'h0;
		for (int i = 7; i >= 0; i--) begin
			mosiDrv = cmd[i];
			gap(8);
			sck = 1'h1;
			r[i] = miso;
			gap(8);
			sck = 1'h0;
		end
		// Released data line shows the inverse, not a stale bit
		mosiDrv = ~cmd[0];
		st = r[4:0];
		gap(8);
		if (!keep)
			csN = 1'h1;
		gap(10);
	endtask

	// Ends a frame that was held open
	task automatic stop();
		csN = 1'h1;
		gap(10);
	endtask
endmodule

/* tb/tb_smart_card_host_control.sv */
/*
 * Bench for the host control block: table of frames, then hand tests.
 * Assumes the host model and design files compile before this one.
 */
`timescale 1ns/1ps
module tb_smart_card_host_control;
	import sch_pkg::*;
	typedef struct packed {
		logic [7:0] cmd;
		logic       pres;
		logic       uv;
		logic       cio;
		logic       attn;
		logic [4:0] st;
	} sch_row_t;

	logic       clk, rst, cardClkSrc, pres, ovl, uv, bo, pe;
	logic       hostDrv, cardDrv, csN, sck, mosiDrv, misoWire;
	logic       hostIoIn, cardIoIn, hostIoOe, cardIoOe, pullupOn;
	logic       misoOut, misoOe, attentionN, supplyOn, cardClk;
	logic [4:0] st;
	logic [7:0] cmd;
	int         failures, compares, cycles, ri, hi, lo;

	// ------------------------------------------------------------
	// Rows: command, pins, expected attention and status
	// ------------------------------------------------------------
	sch_row_t rows[7] = '{
		'{8'h44, 1'h0, 1'h0, 1'h1, 1'h1, 5'h00},
		'{8'h44, 1'h0, 1'h1, 1'h1, 1'h1, 5'h0A},
		'{8'h44, 1'h1, 1'h0, 1'h1, 1'h0, 5'h19},
		'{8'h80, 1'h1, 1'h0, 1'h1, 1'h1, 5'h18},
		'{8'h64, 1'h1, 1'h0, 1'h0, 1'h1, 5'h18},
		'{8'h64, 1'h1, 1'h0, 1'h0, 1'h1, 5'h10},
		'{8'h4C, 1'h1, 1'h0, 1'h1, 1'h1, 5'h18}};

	// Open drain lines: low when either side pulls
	assign hostIoIn = hostDrv & ~hostIoOe;
	assign cardIoIn = cardDrv & ~cardIoOe;
	// Return line has a pull-down while nobody drives it
	assign misoWire = misoOe ? misoOut : 1'h0;

	sch_host_ctrl sch_host_ctrl_i (
		.clk(clk), .rst(rst), .chipAddr(2'h1), .chipSelectN(csN),
		.spiClk(sck), .mosi(mosiDrv), .cardClkSrc(cardClkSrc),
		.card_presence_in(pres), .supplyOverload(ovl),
		.supplyUnderVolt(uv), .brownOut(bo), .pullup_enable_pin(pe),
		.hostIoIn(hostIoIn), .cardIoIn(cardIoIn), .hostIoOut(),
		.hostIoOe(hostIoOe), .cardIoOut(), .cardIoOe(cardIoOe),
		.pullupOn(pullupOn), .misoOut(misoOut), .misoOe(misoOe),
		.attentionN(attentionN), .card_supply_out(supplyOn),
		.card_clock_out(cardClk));

	sch_host_model sch_host_model_i (
		.clk(clk), .miso(misoWire), .csN(csN), .sck(sck),
		.mosiDrv(mosiDrv));

	// 4 ns system clock; card source of 40 ns, unrelated to serial
	initial clk = 1'h0;
	always #2 clk = ~clk;
	initial cardClkSrc = 1'h0;
	always #20 cardClkSrc = ~cardClkSrc;

	// Ceiling well above the roughly 3800 cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			finish_test();
		end
	end

	task automatic gap(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic check(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Window of 400 clk is a whole number of periods for every ratio
	task automatic measure();
		logic prev;
		ri = 0;
		hi = 0;
		lo = 0;
		prev = cardClk;
		repeat (400) begin
			@(negedge clk);
			if (cardClk && !prev)
				ri++;
			if (cardClk)
				hi++;
			else
				lo++;
			prev = cardClk;
		end
	endtask

	task automatic finish_test();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst = 1'h1;
		{pres, ovl, uv, bo} = 4'h0;
		pe = 1'h1;
		hostDrv = 1'h1;
		cardDrv = 1'h1;
		gap(20);
		rst = 1'h0;
		gap(8);
		check("idle outputs", 8'h10, 8'({attentionN, misoOe, supplyOn,
			cardClk, pullupOn}));
		$display("reset test done");
		foreach (rows[i]) begin
			pres = rows[i].pres;
			uv = rows[i].uv;
			cardDrv = rows[i].cio;
			gap(12);
			check("attention", 8'(rows[i].attn), 8'(attentionN));
			sch_host_model_i.xfer(rows[i].cmd, 1'h0, st);
			check("status", 8'(rows[i].st), 8'(st));
			$display("row %0d done", i);
		end
		// Held frames: own chip with and without pullup, then another chip
		for (int k = 0; k < 3; k++) begin
			pe = (k != 1);
			cmd = (k == 2) ? 8'h84 : 8'h44;
			hostDrv = 1'h0;
			sch_host_model_i.xfer(cmd, 1'h1, st);
			check("card io drive", 8'(k != 2), 8'(cardIoOe));
			check("pullup", 8'(k == 0), 8'(pullupOn));
			hostDrv = 1'h1;
			gap(8);
			cardDrv = 1'h0;
			gap(8);
			check("host io drive", 8'(k != 2), 8'(hostIoOe));
			cardDrv = 1'h1;
			sch_host_model_i.stop();
			check("deselected", 8'h00, 8'({misoOe, pullupOn, cardIoOe,
				hostIoOe}));
		end
		$display("translator test done");
		// Card clock ratios and duty
		for (int d = 0; d < 3; d++) begin
			sch_host_model_i.xfer(8'h44 | 8'(d << 3), 1'h0, st);
			gap(20);
			measure();
			check("card clock rises", 8'(40 >> d), 8'(ri));
			check("card clock duty", 8'(hi), 8'(lo));
		end
		$display("divider test done");
		// Overload cuts supply, reports, then recovers on command
		ovl = 1'h1;
		gap(12);
		check("overload", 8'h00, 8'({attentionN, supplyOn}));
		ovl = 1'h0;
		sch_host_model_i.xfer(8'h44, 1'h0, st);
		check("fault status", 8'h15, 8'(st));
		check("released", 8'h01, 8'(attentionN));
		sch_host_model_i.xfer(8'h44, 1'h0, st);
		check("fault cleared", 8'h18, 8'(st));
		$display("overload test done");
		// Extraction, then brown-out masks the pending event
		pres = 1'h0;
		gap(12);
		check("extraction", 8'h00, 8'(attentionN));
		bo = 1'h1;
		gap(12);
		check("brown-out", 8'h01, 8'(attentionN));
		bo = 1'h0;
		gap(12);
		check("still pending", 8'h00, 8'(attentionN));
		sch_host_model_i.xfer(8'h44, 1'h0, st);
		check("extract status", 8'h09, 8'(st));
		check("released", 8'h01, 8'(attentionN));
		$display("brown-out test done");
		finish_test();
	end
endmodule
